/* imdm_memory_map.sv */
`timescale 1ns/10ps
`default_nettype none
`include "imdm_defs.svh"

module imdm_memory_map
  import imdm_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  // Direct access: below 80H goes to RAM, from 80H to registers.
  input wire logic dir_en,
  input wire logic dir_we,
  input wire imdm_byte_t dir_addr,
  input wire imdm_byte_t dir_wdata,
  // Indirect access over the whole 256 byte RAM.
  input wire logic ind_en,
  input wire logic ind_we,
  input wire imdm_byte_t ind_addr,
  input wire imdm_byte_t ind_wdata,
  // Working register access in the active bank.
  input wire logic wreg_en,
  input wire logic wreg_we,
  input wire logic [2:0] wreg_num,
  input wire imdm_byte_t wreg_wdata,
  // Single bit access.
  input wire logic bit_en,
  input wire logic bit_we,
  input wire imdm_byte_t bit_addr,
  input wire logic bit_wdata,
  // Stack push and pop.
  input wire logic stk_push,
  input wire logic stk_pop,
  input wire imdm_byte_t stk_wdata,
  // External move access.
  input wire logic external_move_op,
  input wire logic xmov_we,
  input wire imdm_eaddr_t xmov_addr,
  input wire imdm_byte_t xmov_wdata,
  // Data pointer increment.
  input wire logic data_pointer_inc,
  // Arithmetic results from the core.
  input wire logic alu_flag_we,
  input wire logic alu_carry,
  input wire logic alu_half_carry,
  input wire logic alu_signed_range,
  input wire logic acc_we,
  input wire imdm_byte_t acc_wdata,
  input wire logic muldiv_we,
  input wire imdm_byte_t muldiv_acc,
  input wire imdm_byte_t muldiv_aux,
  // Read answer, one cycle after the request.
  output imdm_byte_t rdata,
  output logic rbit,
  // External data bus strobes.
  output logic ext_req,
  output logic ext_we,
  output imdm_eaddr_t ext_addr,
  output imdm_byte_t ext_wdata,
  output logic port_bus_busy,
  // Register state seen by the core and peripherals.
  output imdm_byte_t acc_q,
  output imdm_byte_t aux_q,
  output imdm_byte_t cpu_flag_word,
  output imdm_byte_t power_ctrl,
  output imdm_eaddr_t data_pointer,
  output imdm_xaddr_t stack_ptr
);

  // -----------------------------------------------------------------------------
  // Storage and registers.
  // -----------------------------------------------------------------------------
  // General purpose RAM, 256 bytes.
  imdm_byte_t iram [`IMDM_IRAM_DEPTH];
  // Stack pointer, low and upper bytes.
  imdm_byte_t stack_ptr_low_r;
  imdm_byte_t stack_ptr_upper_r;
  // Flag word without its parity bit, which is derived.
  imdm_byte_t cpu_flag_word_r;
  imdm_byte_t power_ctrl_r;
  imdm_byte_t ext_stack_cfg_r;
  imdm_byte_t data_ptr_page_r;
  imdm_byte_t data_ptr_high_r;
  imdm_byte_t data_ptr_low_r;
  imdm_byte_t acc_r;
  imdm_byte_t aux_r;
  // Registered read data and its source.
  imdm_byte_t rd_r;
  logic rbit_r;
  imdm_src_t src_r;
  // External bus strobes.
  logic ext_req_r;
  logic ext_we_r;
  imdm_eaddr_t ext_addr_r;
  imdm_byte_t ext_wdata_r;
  // Extended RAM read data.
  imdm_byte_t on_chip_ext_ram_q;

  // -----------------------------------------------------------------------------
  // Helper functions.
  // -----------------------------------------------------------------------------
  // Reads a special function register; unused offsets return zero.
  function automatic imdm_byte_t sfr_read(input imdm_byte_t a);
    imdm_byte_t v;
    v = `IMDM_RST_BYTE;
    case (a)
      `IMDM_SFR_STACK_PTR_LOW: v = stack_ptr_low_r;
      `IMDM_SFR_STACK_PTR_UPPER: v = stack_ptr_upper_r;
      `IMDM_SFR_DATA_PTR_LOW: v = data_ptr_low_r;
      `IMDM_SFR_DATA_PTR_HIGH: v = data_ptr_high_r;
      `IMDM_SFR_DATA_PTR_PAGE: v = data_ptr_page_r;
      `IMDM_SFR_POWER_CTRL: v = power_ctrl_r;
      `IMDM_SFR_EXT_STACK_CFG: v = ext_stack_cfg_r;
      `IMDM_SFR_CPU_FLAG_WORD: v = cpu_flag_word;
      `IMDM_SFR_ACCUM: v = acc_r;
      `IMDM_SFR_AUX_OPERAND: v = aux_r;
      default: v = `IMDM_RST_BYTE;
    endcase
    return v;
  endfunction

  // Reads a byte of the direct space: RAM below 80H, registers above.
  function automatic imdm_byte_t direct_read(input imdm_byte_t a);
    return a[7] ? sfr_read(a) : iram[a];
  endfunction

  // -----------------------------------------------------------------------------
  // Mode and address decoding.
  // -----------------------------------------------------------------------------
  // Configuration bits.
  wire logic ext_stack_en = ext_stack_cfg_r[`IMDM_CFG_EXT_STACK_EN];
  wire logic ext_ram_en = ext_stack_cfg_r[`IMDM_CFG_EXT_RAM_EN];
  // Bank base from the two select bits.
  wire logic [1:0] bank_sel = {cpu_flag_word_r[`IMDM_FLAG_BANK_HI],
                               cpu_flag_word_r[`IMDM_FLAG_BANK_LO]};
  wire imdm_byte_t wreg_addr = {3'b000, bank_sel, wreg_num};
  // Upper pointer bits count only with the extended stack on.
  wire imdm_xaddr_t sp_cur = ext_stack_en ? {stack_ptr_upper_r[2:0], stack_ptr_low_r}
                                          : {3'b000, stack_ptr_low_r};
  // Push adds first; without extension the carry out of bit 7 is lost.
  wire imdm_xaddr_t sp_inc = ext_stack_en ? imdm_xaddr_t'(sp_cur + 11'd1)
                                          : {3'b000, stack_ptr_low_r + 8'h01};
  wire imdm_xaddr_t sp_dec = ext_stack_en ? imdm_xaddr_t'(sp_cur - 11'd1)
                                          : {3'b000, stack_ptr_low_r - 8'h01};
  // Push writes at the new pointer, pop reads at the current one.
  wire imdm_xaddr_t stk_addr = stk_push ? sp_inc : sp_cur;
  // Above FFH the stack lives in extended RAM, 0100H to 07FFH.
  wire logic stk_in_on_chip_ext_ram = ext_stack_en && (stk_addr[10:8] != 3'b000);
  // Bit address to byte: low half in 20H-2FH, high half in registers.
  wire imdm_byte_t bit_byte = bit_addr[7] ? {bit_addr[7:3], 3'b000}
                                          : (`IMDM_BIT_AREA_BASE + {4'h0, bit_addr[6:3]});
  // A process, so that it follows every register the function reads, not only its argument.
  imdm_byte_t bit_old;
  always_comb bit_old = direct_read(bit_byte);
  wire imdm_byte_t bit_new = (bit_old & ~(8'h01 << bit_addr[2:0])) |
                             ({7'h00, bit_wdata} << bit_addr[2:0]);
  // External move hits on-chip memory only in the bottom 2 kBytes.
  wire logic xmov_local = ext_ram_en && (xmov_addr < `IMDM_ON_CHIP_EXT_RAM_LIMIT);

  // Request selection, one request per cycle, stack first.
  wire logic do_stk = stk_push || stk_pop;
  wire logic do_wreg = !do_stk && wreg_en;
  wire logic do_dir = !do_stk && !wreg_en && dir_en;
  wire logic do_ind = !do_stk && !wreg_en && !dir_en && ind_en;
  wire logic do_bit = !do_stk && !wreg_en && !dir_en && !ind_en && bit_en;
  wire logic do_xmov = !do_stk && !wreg_en && !dir_en && !ind_en && !bit_en && external_move_op;

  // -----------------------------------------------------------------------------
  // Internal RAM write port.
  // -----------------------------------------------------------------------------
  // Direct writes above 7FH never reach RAM; indirect writes always do.
  wire logic ram_we = (do_stk && stk_push && !stk_in_on_chip_ext_ram) ||
                      (do_wreg && wreg_we) ||
                      (do_dir && dir_we && !dir_addr[7]) ||
                      (do_ind && ind_we) ||
                      (do_bit && bit_we && !bit_byte[7]);
  wire imdm_byte_t ram_wa = do_stk ? stk_addr[7:0] :
                            do_wreg ? wreg_addr :
                            do_dir ? dir_addr :
                            do_ind ? ind_addr : bit_byte;
  wire imdm_byte_t ram_wd = do_stk ? stk_wdata :
                            do_wreg ? wreg_wdata :
                            do_dir ? dir_wdata :
                            do_ind ? ind_wdata : bit_new;

  // Stores one byte into general purpose RAM.
  always_ff @(posedge core_clk) begin
    if (ram_we) begin
      iram[ram_wa] <= ram_wd;
    end
  end

  // -----------------------------------------------------------------------------
  // Register write port.
  // -----------------------------------------------------------------------------
  wire logic sfr_we = (do_dir && dir_we && dir_addr[7]) ||
                      (do_bit && bit_we && bit_byte[7]);
  wire imdm_byte_t sfr_wa = do_dir ? dir_addr : bit_byte;
  wire imdm_byte_t sfr_wd = do_dir ? dir_wdata : bit_new;
  // Decoded write strobes per register.
  wire logic wr_sp = sfr_we && (sfr_wa == `IMDM_SFR_STACK_PTR_LOW);
  wire logic wr_sph = sfr_we && (sfr_wa == `IMDM_SFR_STACK_PTR_UPPER);
  wire logic wr_dpl = sfr_we && (sfr_wa == `IMDM_SFR_DATA_PTR_LOW);
  wire logic wr_dph = sfr_we && (sfr_wa == `IMDM_SFR_DATA_PTR_HIGH);
  wire logic wr_dpp = sfr_we && (sfr_wa == `IMDM_SFR_DATA_PTR_PAGE);
  wire logic wr_power_ctrl = sfr_we && (sfr_wa == `IMDM_SFR_POWER_CTRL);
  wire logic wr_cfg = sfr_we && (sfr_wa == `IMDM_SFR_EXT_STACK_CFG);
  wire logic wr_psw = sfr_we && (sfr_wa == `IMDM_SFR_CPU_FLAG_WORD);
  wire logic wr_acc = sfr_we && (sfr_wa == `IMDM_SFR_ACCUM);
  wire logic wr_aux = sfr_we && (sfr_wa == `IMDM_SFR_AUX_OPERAND);

  // Next values; a register write wins over the core's own update.
  wire imdm_xaddr_t sp_nxt = stk_push ? sp_inc : sp_dec;
  wire imdm_byte_t stack_ptr_low_nxt = wr_sp ? sfr_wd :
                                       do_stk ? sp_nxt[7:0] : stack_ptr_low_r;
  wire imdm_byte_t stack_ptr_upper_nxt = wr_sph ? sfr_wd :
                                         (do_stk && ext_stack_en) ? {stack_ptr_upper_r[7:3], sp_nxt[10:8]}
                                                                  : stack_ptr_upper_r;
  // Pointer increment carries from the high byte into the page byte.
  wire logic [16:0] data_pointer_sum = {1'b0, data_ptr_high_r, data_ptr_low_r} + 17'd1;
  wire imdm_byte_t data_ptr_low_nxt = wr_dpl ? sfr_wd :
                                      data_pointer_inc ? data_pointer_sum[7:0] : data_ptr_low_r;
  wire imdm_byte_t data_ptr_high_nxt = wr_dph ? sfr_wd :
                                       data_pointer_inc ? data_pointer_sum[15:8] : data_ptr_high_r;
  wire imdm_byte_t data_ptr_page_nxt = wr_dpp ? sfr_wd :
                                       data_pointer_inc ? data_ptr_page_r + {7'h00, data_pointer_sum[16]}
                                                        : data_ptr_page_r;
  // Arithmetic flags come from the core unless software writes the word.
  wire imdm_byte_t alu_flags = {alu_carry, alu_half_carry, cpu_flag_word_r[5:3],
                                alu_signed_range, cpu_flag_word_r[1:0]};
  wire imdm_byte_t cpu_flag_word_nxt = wr_psw ? sfr_wd :
                                       alu_flag_we ? alu_flags : cpu_flag_word_r;
  // Multiply and divide load both operand registers together.
  wire imdm_byte_t acc_nxt = wr_acc ? sfr_wd :
                             muldiv_we ? muldiv_acc :
                             acc_we ? acc_wdata : acc_r;
  wire imdm_byte_t aux_nxt = wr_aux ? sfr_wd :
                             muldiv_we ? muldiv_aux : aux_r;

  // Stack pointer, loaded with 07H so the first push lands at 08H.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stack_ptr_low_r <= `IMDM_RST_STACK_PTR_LOW;
      stack_ptr_upper_r <= `IMDM_RST_STACK_PTR_UPPER;
    end else begin
      stack_ptr_low_r <= stack_ptr_low_nxt;
      stack_ptr_upper_r <= stack_ptr_upper_nxt;
    end
  end

  // Data pointer bytes.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      data_ptr_low_r <= `IMDM_RST_BYTE;
      data_ptr_high_r <= `IMDM_RST_BYTE;
      data_ptr_page_r <= `IMDM_RST_BYTE;
    end else begin
      data_ptr_low_r <= data_ptr_low_nxt;
      data_ptr_high_r <= data_ptr_high_nxt;
      data_ptr_page_r <= data_ptr_page_nxt;
    end
  end

  // Flag word, power control and configuration.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cpu_flag_word_r <= `IMDM_RST_CPU_FLAG_WORD;
      power_ctrl_r <= `IMDM_RST_POWER_CTRL;
      ext_stack_cfg_r <= `IMDM_RST_EXT_STACK_CFG;
    end else begin
      cpu_flag_word_r <= cpu_flag_word_nxt;
      power_ctrl_r <= wr_power_ctrl ? sfr_wd : power_ctrl_r;
      ext_stack_cfg_r <= wr_cfg ? sfr_wd : ext_stack_cfg_r;
    end
  end

  // Accumulator and auxiliary operand.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      acc_r <= `IMDM_RST_BYTE;
      aux_r <= `IMDM_RST_BYTE;
    end else begin
      acc_r <= acc_nxt;
      aux_r <= aux_nxt;
    end
  end

  // -----------------------------------------------------------------------------
  // Extended RAM.
  // -----------------------------------------------------------------------------
  // Stack traffic above FFH and local external moves share the one port.
  wire logic on_chip_ext_ram_req = (do_stk && stk_in_on_chip_ext_ram) || (do_xmov && xmov_local);
  wire logic on_chip_ext_ram_we = do_stk ? stk_push : xmov_we;
  wire imdm_xaddr_t on_chip_ext_ram_addr = do_stk ? stk_addr : xmov_addr[10:0];
  wire imdm_byte_t on_chip_ext_ram_wd = do_stk ? stk_wdata : xmov_wdata;

  imdm_ext_ram u_ext_ram (
    .core_clk(core_clk),
    .req(on_chip_ext_ram_req),
    .we(on_chip_ext_ram_we),
    .addr(on_chip_ext_ram_addr),
    .wdata(on_chip_ext_ram_wd),
    .rdata(on_chip_ext_ram_q)
  );

  // -----------------------------------------------------------------------------
  // Read path.
  // -----------------------------------------------------------------------------
  // Byte read from the local spaces this cycle.
  // Kept in a process so that a register updated under a steady address is still seen.
  imdm_byte_t local_rd;
  always_comb local_rd = do_stk ? iram[stk_addr[7:0]] :
                         do_wreg ? iram[wreg_addr] :
                         do_dir ? direct_read(dir_addr) :
                         do_ind ? iram[ind_addr] : bit_old;
  wire logic rd_local = (do_stk && stk_pop && !stk_in_on_chip_ext_ram) || (do_wreg && !wreg_we) ||
                        (do_dir && !dir_we) || (do_ind && !ind_we) || (do_bit && !bit_we);
  wire logic rd_on_chip_ext_ram = on_chip_ext_ram_req && !on_chip_ext_ram_we;

  // Captures read data and remembers where it came from.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rd_r <= `IMDM_RST_BYTE;
      rbit_r <= 1'b0;
      src_r <= IMDM_SRC_NONE;
    end else begin
      rd_r <= rd_local ? local_rd : rd_r;
      rbit_r <= (do_bit && !bit_we) ? bit_old[bit_addr[2:0]] : rbit_r;
      src_r <= rd_on_chip_ext_ram ? IMDM_SRC_ON_CHIP_EXT_RAM : (rd_local ? IMDM_SRC_LOCAL : src_r);
    end
  end

  // -----------------------------------------------------------------------------
  // External bus strobes.
  // -----------------------------------------------------------------------------
  // Off-chip moves raise the strobe for one cycle with a 24-bit address.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ext_req_r <= 1'b0;
      ext_we_r <= 1'b0;
      ext_addr_r <= 24'h000000;
      ext_wdata_r <= `IMDM_RST_BYTE;
    end else begin
      ext_req_r <= do_xmov && !xmov_local;
      ext_we_r <= do_xmov && !xmov_local && xmov_we;
      ext_addr_r <= (do_xmov && !xmov_local) ? xmov_addr : ext_addr_r;
      ext_wdata_r <= (do_xmov && !xmov_local) ? xmov_wdata : ext_wdata_r;
    end
  end

  // -----------------------------------------------------------------------------
  // Outputs.
  // -----------------------------------------------------------------------------
  assign rdata = (src_r == IMDM_SRC_ON_CHIP_EXT_RAM) ? on_chip_ext_ram_q : rd_r;
  assign rbit = rbit_r;
  assign ext_req = ext_req_r;
  assign ext_we = ext_we_r;
  assign ext_addr = ext_addr_r;
  assign ext_wdata = ext_wdata_r;
  // Ports 0 and 2 are claimed only by an off-chip cycle.
  assign port_bus_busy = ext_req_r;
  assign acc_q = acc_r;
  assign aux_q = aux_r;
  // Parity is even parity of the accumulator, live every cycle.
  assign cpu_flag_word = {cpu_flag_word_r[7:1], ^acc_r};
  assign power_ctrl = power_ctrl_r;
  assign data_pointer = {data_ptr_page_r, data_ptr_high_r, data_ptr_low_r};
  assign stack_ptr = sp_cur;

endmodule
`default_nettype wire

/* imdm_defs.svh */
`ifndef IMDM_DEFS_SVH
`define IMDM_DEFS_SVH

// -----------------------------------------------------------------------------
// Special function register offsets in the direct address space.
// -----------------------------------------------------------------------------
`define IMDM_SFR_STACK_PTR_LOW 8'h81
`define IMDM_SFR_DATA_PTR_LOW 8'h82
`define IMDM_SFR_DATA_PTR_HIGH 8'h83
`define IMDM_SFR_DATA_PTR_PAGE 8'h84
`define IMDM_SFR_POWER_CTRL 8'h87
`define IMDM_SFR_EXT_STACK_CFG 8'haf
`define IMDM_SFR_STACK_PTR_UPPER 8'hb7
`define IMDM_SFR_CPU_FLAG_WORD 8'hd0
`define IMDM_SFR_ACCUM 8'he0
`define IMDM_SFR_AUX_OPERAND 8'hf0

// -----------------------------------------------------------------------------
// Reset values.
// -----------------------------------------------------------------------------
`define IMDM_RST_STACK_PTR_LOW 8'h07
`define IMDM_RST_STACK_PTR_UPPER 8'h00
`define IMDM_RST_POWER_CTRL 8'h00
`define IMDM_RST_CPU_FLAG_WORD 8'h00
`define IMDM_RST_EXT_STACK_CFG 8'h00
`define IMDM_RST_BYTE 8'h00

// -----------------------------------------------------------------------------
// Field positions.
// -----------------------------------------------------------------------------
`define IMDM_FLAG_CARRY 7
`define IMDM_FLAG_HALF_CARRY 6
`define IMDM_FLAG_USER_ZERO 5
`define IMDM_FLAG_BANK_HI 4
`define IMDM_FLAG_BANK_LO 3
`define IMDM_FLAG_SIGNED_RANGE 2
`define IMDM_FLAG_USER_ONE 1
`define IMDM_FLAG_PARITY 0
`define IMDM_PWR_BAUD_DOUBLER 7
`define IMDM_PWR_SERIAL_WAKE 6
`define IMDM_PWR_EXT_IRQ0_WAKE 5
`define IMDM_PWR_LATCH_DISABLE 4
`define IMDM_PWR_USER_B 3
`define IMDM_PWR_USER_A 2
`define IMDM_PWR_DEEP_SLEEP 1
`define IMDM_PWR_CORE_HALT 0
`define IMDM_CFG_EXT_STACK_EN 7
`define IMDM_CFG_EXT_RAM_EN 0

// -----------------------------------------------------------------------------
// Memory geometry.
// -----------------------------------------------------------------------------
`define IMDM_IRAM_DEPTH 256
`define IMDM_ON_CHIP_EXT_RAM_DEPTH 2048
`define IMDM_SFR_BASE 8'h80
`define IMDM_BIT_AREA_BASE 8'h20
`define IMDM_ON_CHIP_EXT_RAM_LIMIT 24'h000800

`endif

/* imdm_pkg.sv */
package imdm_pkg;

  // One byte of data memory or register space.
  typedef logic [7:0] imdm_byte_t;

  // Eleven bit stack pointer and on-chip extended RAM address.
  typedef logic [10:0] imdm_xaddr_t;

  // Twenty-four bit external data address.
  typedef logic [23:0] imdm_eaddr_t;

  // Source that the registered read data was taken from.
  typedef enum logic [1:0] {
    IMDM_SRC_NONE = 2'b00,
    IMDM_SRC_LOCAL = 2'b01,
    IMDM_SRC_ON_CHIP_EXT_RAM = 2'b10
  } imdm_src_t;

endpackage

/* imdm_ext_ram.sv */
`timescale 1ns/10ps
`default_nettype none
`include "imdm_defs.svh"

// On-chip extended RAM, one port, read data unchanged by a write, registered read.
module imdm_ext_ram
  import imdm_pkg::*;
(
  input wire logic core_clk,
  input wire logic req,
  input wire logic we,
  input wire imdm_xaddr_t addr,
  input wire imdm_byte_t wdata,
  output imdm_byte_t rdata
);

  // -----------------------------------------------------------------------------
  // Storage.
  // -----------------------------------------------------------------------------
  // The array holds no reset so that it maps onto a plain RAM macro.
  imdm_byte_t mem [`IMDM_ON_CHIP_EXT_RAM_DEPTH];

  // A write stores the byte; a read presents it on the next edge.
  always_ff @(posedge core_clk) begin
    if (req && we) begin
      mem[addr] <= wdata;
    end
    if (req && !we) begin
      rdata <= mem[addr];
    end
  end

endmodule
`default_nettype wire

/* imdm_alu_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Arithmetic side of the core: op 1 adds, op 2 multiplies, op 0 is idle.
module imdm_alu_model
  import imdm_pkg::*;
(
  input wire logic [1:0] op,
  input wire imdm_byte_t opa, opb,
  output logic acc_we, muldiv_we, alu_flag_we, alu_carry, alu_half_carry, alu_signed_range,
  output imdm_byte_t acc_wdata, muldiv_acc, muldiv_aux
);
  // Results depend only on the operands, so holding op for extra cycles is harmless.
  wire logic [8:0] sum = {1'b0, opa} + {1'b0, opb};
  wire logic [15:0] prod = 16'(opa) * 16'(opb);
  assign acc_we = (op == 2'd1);
  assign alu_flag_we = acc_we;
  assign muldiv_we = (op == 2'd2);
  assign acc_wdata = sum[7:0];
  assign alu_carry = sum[8];
  assign alu_half_carry = ({1'b0, opa[3:0]} + {1'b0, opb[3:0]}) > 5'd15;
  assign alu_signed_range = (opa[7] == opb[7]) && (sum[7] != opa[7]);
  assign {muldiv_aux, muldiv_acc} = prod;
endmodule
`default_nettype wire

/* imdm_memory_map_props.sv */
`timescale 1ns/10ps
`default_nettype none
// Checker on the top ports; all assertions share the core clock.
module imdm_memory_map_props
  import imdm_pkg::*;
(
  input wire logic core_clk, rst_n, dir_en, dir_we, stk_push, stk_pop, wreg_en, ind_en, bit_en,
  input wire logic external_move_op, data_pointer_inc, ext_req, port_bus_busy,
  input wire imdm_byte_t dir_addr, rdata, acc_q, cpu_flag_word,
  input wire imdm_eaddr_t xmov_addr, ext_addr, data_pointer,
  input wire imdm_xaddr_t stack_ptr
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_parity_live: assert property (cpu_flag_word[0] == ^acc_q)
    else $error("parity off");
  a_reset_sp: assert property (@(posedge core_clk) disable iff (1'b0) !rst_n
    |=> stack_ptr == 11'h007) else $error("stack reset");
  a_push_inc: assert property (stk_push && !dir_en && stack_ptr[7:0] != 8'hff
    |=> stack_ptr[7:0] == $past(stack_ptr[7:0]) + 8'h1) else $error("push step");
  a_stack_wrap: assert property (stk_push && !dir_en && stack_ptr == 11'h0ff
    |=> stack_ptr[7:0] == 8'h00) else $error("stack wrap");
  a_data_pointer_carry: assert property (data_pointer_inc && !dir_en
    |=> data_pointer == $past(data_pointer) + 24'h1) else $error("pointer step");
  a_ext_pulse: assert property (external_move_op && xmov_addr >= 24'h000800 &&
    !(stk_push | stk_pop | wreg_en | dir_en | ind_en | bit_en) |=> ext_req && ext_addr == $past(xmov_addr))
    else $error("bus cycle");
  a_bus_free: assert property (port_bus_busy |-> ext_req && $past(external_move_op))
    else $error("ports busy");
  a_sp_read: assert property (dir_en && !dir_we && dir_addr == 8'h81 && !stk_push && !stk_pop
    && !wreg_en |=> rdata == $past(stack_ptr[7:0])) else $error("pointer read");
  c_wrap: cover property (stk_push && stack_ptr == 11'h0ff);
  c_bus: cover property (ext_req);
  c_carry: cover property (data_pointer_inc && data_pointer[15:0] == 16'hffff);
endmodule
bind imdm_memory_map imdm_memory_map_props props_u (.*);
`default_nettype wire

/* imdm_memory_map_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; $display("unexpected %0t value mismatch", $time); end end
module imdm_memory_map_tb_top
  import imdm_pkg::*;
;
  logic core_clk = 0, rst_n = 0, dir_en, dir_we, ind_en, ind_we, wreg_en, wreg_we, bit_en, bit_we, bit_wdata;
  logic stk_push, stk_pop, external_move_op, xmov_we, data_pointer_inc, rbit, ext_req, ext_we, port_bus_busy;
  logic acc_we, muldiv_we, alu_flag_we, alu_carry, alu_half_carry, alu_signed_range;
  logic [2:0] wreg_num;
  logic [1:0] op;
  imdm_byte_t dir_addr, dir_wdata, ind_addr, ind_wdata, wreg_wdata, bit_addr, stk_wdata, xmov_wdata, opa, opb;
  imdm_byte_t acc_wdata, muldiv_acc, muldiv_aux, rdata, ext_wdata, acc_q, aux_q, cpu_flag_word, power_ctrl;
  imdm_eaddr_t xmov_addr, ext_addr, data_pointer;
  imdm_xaddr_t stack_ptr;
  int fail_count = 0, total_checks = 0, cycles = 0;
  // Strobe patterns, one per request kind except working register read, which has none.
  localparam logic [12:0] dw = 13'h1800, dr = 13'h1000, iw = 13'h0600, ir = 13'h0400, ww = 13'h0180;
  localparam logic [12:0] bw = 13'h0060, br = 13'h0040, pu = 13'h0010, po = 13'h0008, xw = 13'h0006;
  localparam logic [12:0] xr = 13'h0004, ic = 13'h0001;
  imdm_memory_map dut_u (.*);
  imdm_alu_model core_u (.*);
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  // Ceiling on run length; a hang counts as a mismatch.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 500) begin
      fail_count++;
      tally_and_finish();
    end
  end
  // One request for one cycle; every strobe is set in one assignment at the falling edge.
  task automatic go(input logic [12:0] s, input imdm_eaddr_t a, input imdm_byte_t d);
    {dir_addr, ind_addr, bit_addr, wreg_num, xmov_addr} = {a[7:0], a[7:0], a[7:0], a[2:0], a};
    {dir_wdata, ind_wdata, stk_wdata, wreg_wdata, xmov_wdata, bit_wdata} = {d, d, d, d, d, d[0]};
    {dir_en, dir_we, ind_en, ind_we, wreg_en, wreg_we, bit_en, bit_we, stk_push, stk_pop, external_move_op,
      xmov_we, data_pointer_inc} = s;
    @(negedge core_clk);
  endtask
  task automatic t_banks();
    for (int b = 0; b < 4; b++) begin
      go(dw, 24'hd0, {3'b0, b[1:0], 3'b0});
      go(ww, 24'h5, 8'(64 + b));
      go(ir, 24'(8 * b + 5), 8'h0);
      `CHK(rdata, 8'(64 + b))
      go(dr, 24'(8 * b + 5), 8'h0);
      `CHK(rdata, 8'(64 + b))
    end
    go(dw, 24'hd0, 8'h00);
  endtask
  task automatic t_upper();
    go(iw, 24'h90, 8'h5a);
    go(dw, 24'h90, 8'ha5);
    go(ir, 24'h90, 8'h0);
    `CHK(rdata, 8'h5a)
    go(dr, 24'h90, 8'h0);
    `CHK(rdata, 8'h00)
    go(dw, 24'hb7, 8'h05);
    go(dr, 24'hb7, 8'h0);
    `CHK({rdata, stack_ptr}, {8'h05, 11'h007})
    go(dw, 24'h21, 8'h00);
    go(bw, 24'h0b, 8'h01);
    go(dr, 24'h21, 8'h0);
    `CHK(rdata, 8'h08)
    go(dw, 24'h2f, 8'h80);
    go(br, 24'h7f, 8'h0);
    `CHK(rbit, 1'b1)
    go(bw, 24'hd3, 8'h01);
    go(dr, 24'hd0, 8'h0);
    `CHK(rdata, 8'h08)
    go(dw, 24'hd0, 8'h00);
  endtask
  task automatic t_stack();
    go(dw, 24'hb7, 8'h00);
    go(dw, 24'h81, 8'hfe);
    go(dr, 24'h81, 8'h0);
    `CHK(rdata, 8'hfe)
    go(pu, 24'h0, 8'haa);
    go(pu, 24'h0, 8'hbb);
    `CHK(stack_ptr, 11'h000)
    go(ir, 24'hff, 8'h0);
    `CHK(rdata, 8'haa)
    go(po, 24'h0, 8'h0);
    `CHK({rdata, stack_ptr}, {8'hbb, 11'h0ff})
    go(dw, 24'haf, 8'h81);
    go(pu, 24'h0, 8'hcc);
    `CHK(stack_ptr, 11'h100)
    go(xr, 24'h100, 8'h0);
    `CHK({rdata, port_bus_busy}, {8'hcc, 1'b0})
    go(xw, 24'h0007ff, 8'h77);
    go(xr, 24'h0007ff, 8'h0);
    `CHK({rdata, ext_req}, {8'h77, 1'b0})
    go(xr, 24'h800, 8'h0);
    `CHK({ext_req, port_bus_busy, ext_addr}, {2'b11, 24'h000800})
    go(dw, 24'haf, 8'h80);
    go(xr, 24'h100, 8'h0);
    `CHK(ext_req, 1'b1)
    go(xw, 24'h123456, 8'h3c);
    `CHK({ext_req, ext_we, ext_addr, ext_wdata}, {2'b11, 24'h123456, 8'h3c})
    go(dw, 24'haf, 8'h00);
  endtask
  task automatic t_regs();
    go(dw, 24'h82, 8'hff);
    go(dw, 24'h83, 8'hff);
    go(dw, 24'h84, 8'h01);
    go(ic, 24'h0, 8'h0);
    `CHK(data_pointer, 24'h020000)
    {op, opa, opb} = {2'd1, 8'hc8, 8'h48};
    go(dw, 24'h87, 8'ha5);
    `CHK({power_ctrl, acc_q, cpu_flag_word}, {8'ha5, 8'h10, 8'hc1})
    {op, opa, opb} = {2'd1, 8'h7f, 8'h01};
    go(13'h0, 24'h0, 8'h0);
    `CHK({acc_q, cpu_flag_word}, {8'h80, 8'h45})
    {op, opa, opb} = {2'd2, 8'h10, 8'h23};
    go(13'h0, 24'h0, 8'h0);
    `CHK({aux_q, acc_q}, 16'h0230)
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    {op, opa, opb} = '0;
    go(13'h0, 24'h0, 8'h0);
    repeat (5) @(negedge core_clk);
    rst_n = 1'b1;
    `CHK({stack_ptr, power_ctrl, cpu_flag_word, data_pointer}, {11'h007, 8'h00, 8'h00, 24'h000000})
    t_banks();
    t_upper();
    t_stack();
    t_regs();
    tally_and_finish();
  end
endmodule
`default_nettype wire
